// ---- rtl/chgsup_top.sv ----
// Charge fault supervisor: battery-absent detection, timer fault recovery,
// overvoltage protection and host rate control, with a Wishbone register file.
// Assumes comparator flags and host pins are synchronous to clk_i.
`include "chgsup_cfg.svh"
`default_nettype none
module chgsup_top
  import chgsup_pkg::*;
#(
  parameter logic [31:0] DETECT_CYCLES = 32'(`CHGSUP_DETECT_CYCLES),
  parameter logic [31:0] CHARGE_CYCLES = 32'(`CHGSUP_CHARGE_CYCLES)
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Comparator flags
  input wire logic below_recharge_i,
  input wire logic below_precharge_i,
  input wire logic at_regulation_i,
  input wire logic overvoltage_i,
  input wire logic term_current_i,
  // Host pins
  input wire logic charge_enable_n_i,
  input wire logic timer_termination_enable_i,
  input wire logic charge_rate_select_i,
  // Power stage and status
  output logic detect_current_en_o,
  output logic fast_current_sel_o,
  output logic pwm_en_o,
  output logic status_out_a_o,
  output logic status_out_b_o
);
  chgsup_state_e state; // Sequencer state
  chgsup_state_e next_state; // Next sequencer state
  logic [1:0] ctrl; // Control register
  logic en_n_q; // Previous charge enable
  logic tte_q; // Previous timer enable
  logic fault_clear; // Toggle-driven clear
  logic host_mode; // System-controlled variant
  logic timers_on; // Safety timer active
  logic wb_hit; // Valid bus request this cycle
  logic [31:0] next_dat; // Read mux
  chgsup_tmr_if det_if (); // Detection period
  chgsup_tmr_if chg_if (); // Charge safety timer

  assign host_mode = ctrl[`CHGSUP_CTRL_HOSTMODE];
  // Host variant has no timers or termination
  assign timers_on = ctrl[`CHGSUP_CTRL_TIMER_EN] && timer_termination_enable_i && !host_mode;

  // True in any charging state
  function automatic logic is_charging(input chgsup_state_e s);
    is_charging = (s == CHGSUP_PRE) || (s == CHGSUP_FAST) || (s == CHGSUP_REG);
  endfunction : is_charging

  // Period timer instances
  chgsup_timer u_det (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(clk_en_i),
    .t(det_if.tmr)
  );
  chgsup_timer u_chg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(clk_en_i),
    .t(chg_if.tmr)
  );

  // Detection timer restarts on every state change
  assign det_if.start = (next_state != state);
  assign det_if.run = (state == CHGSUP_DET1) || (state == CHGSUP_DET2);
  assign det_if.limit = DETECT_CYCLES;
  // Safety timer spans one charge cycle
  assign chg_if.start = !is_charging(state);
  assign chg_if.run = timers_on;
  assign chg_if.limit = CHARGE_CYCLES;

  // Edge history of host pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_n_q <= 1'b1;
      tte_q <= 1'b0;
    end else if (clk_en_i) begin
      en_n_q <= charge_enable_n_i;
      tte_q <= timer_termination_enable_i;
    end
  end

  // Falling enable or any timer-enable toggle clears timer faults
  assign fault_clear = (en_n_q && !charge_enable_n_i)
    || (tte_q != timer_termination_enable_i);

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      CHGSUP_IDLE: begin
        if (!charge_enable_n_i) begin
          next_state = CHGSUP_PRE;
        end
      end
      CHGSUP_PRE, CHGSUP_FAST: begin
        if (at_regulation_i) begin
          next_state = CHGSUP_REG;
        end else if (chg_if.expired && timers_on) begin
          next_state = below_recharge_i ? CHGSUP_TFLT_LO : CHGSUP_TFLT_HI;
        end else if (host_mode) begin
          next_state = charge_rate_select_i ? CHGSUP_FAST : CHGSUP_PRE;
        end else begin
          next_state = below_precharge_i ? CHGSUP_PRE : CHGSUP_FAST;
        end
      end
      CHGSUP_REG: begin
        if (chg_if.expired && timers_on) begin
          next_state = below_recharge_i ? CHGSUP_TFLT_LO : CHGSUP_TFLT_HI;
        end else if (term_current_i && timers_on) begin
          next_state = CHGSUP_DONE;
        end
      end
      CHGSUP_DONE: begin
        if (below_recharge_i) begin
          next_state = CHGSUP_DET1;
        end
      end
      CHGSUP_DET1: begin
        if (det_if.expired) begin
          next_state = below_precharge_i ? CHGSUP_DET2 : CHGSUP_PRE;
        end
      end
      CHGSUP_DET2: begin
        if (det_if.expired) begin
          next_state = !below_recharge_i ? CHGSUP_ABSENT : CHGSUP_PRE;
        end
      end
      CHGSUP_ABSENT: begin
        next_state = CHGSUP_PRE;
      end
      CHGSUP_TFLT_HI: begin
        if (below_recharge_i) begin
          next_state = CHGSUP_DET1;
        end
      end
      CHGSUP_TFLT_LO: begin
        if (!below_recharge_i) begin
          next_state = CHGSUP_TFLT_HI;
        end
      end
      CHGSUP_OVP: begin
        if (below_recharge_i) begin
          next_state = CHGSUP_IDLE;
        end
      end
      default: begin
        next_state = CHGSUP_IDLE;
      end
    endcase
    // Overrides in order of priority
    if (charge_enable_n_i) begin
      next_state = CHGSUP_IDLE;
    end else if (overvoltage_i && state != CHGSUP_OVP) begin
      next_state = CHGSUP_OVP;
    end else if (fault_clear && (state == CHGSUP_TFLT_HI || state == CHGSUP_TFLT_LO)) begin
      next_state = CHGSUP_PRE;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CHGSUP_IDLE;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  // Power stage outputs, registered from next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_current_en_o <= 1'b0;
      fast_current_sel_o <= 1'b0;
      pwm_en_o <= 1'b0;
    end else if (clk_en_i) begin
      detect_current_en_o <= (next_state == CHGSUP_DET1) || (next_state == CHGSUP_TFLT_LO);
      fast_current_sel_o <= (next_state == CHGSUP_FAST) || (next_state == CHGSUP_REG);
      // Precharge current in phase two; nothing in overvoltage
      pwm_en_o <= is_charging(next_state) || (next_state == CHGSUP_DET2);
    end
  end

  // Status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_out_a_o <= 1'b0;
      status_out_b_o <= 1'b0;
    end else if (clk_en_i) begin
      status_out_a_o <= is_charging(next_state);
      status_out_b_o <= (next_state == CHGSUP_DONE);
    end
  end

  // Bus request decode
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Control register write, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CHGSUP_CTRL_RST;
    end else if (clk_en_i && wb_hit && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `CHGSUP_REG_CTRL) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_dat = 32'h0;
    unique case (wb_adr_i)
      `CHGSUP_REG_CTRL: next_dat = {30'h0, ctrl};
      `CHGSUP_REG_STATUS: next_dat = {24'h0, det_if.expired, chg_if.expired,
                                      timers_on, 1'b0, state};
      `CHGSUP_REG_DETCNT: next_dat = DETECT_CYCLES;
      default: next_dat = 32'h0;
    endcase
  end

  // Ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en_i) begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end
endmodule : chgsup_top
`default_nettype wire

// ---- rtl/chgsup_cfg.svh ----
// Constants for the charge fault supervisor: register offsets, fields, resets, timing.
// Assumes a 50 MHz clock and a 32-bit classic Wishbone register bus.
`ifndef CHGSUP_CFG_SVH
`define CHGSUP_CFG_SVH
// Register byte offsets
`define CHGSUP_REG_CTRL 4'h0
`define CHGSUP_REG_STATUS 4'h4
`define CHGSUP_REG_DETCNT 4'h8
// Control field positions
`define CHGSUP_CTRL_HOSTMODE 0
`define CHGSUP_CTRL_TIMER_EN 1
// Control reset value
`define CHGSUP_CTRL_RST 2'h2
// Detection period in microseconds and derived cycles (50 MHz clock)
`define CHGSUP_T_DETECT_US 100
`define CHGSUP_CLK_MHZ 50
`define CHGSUP_DETECT_CYCLES (`CHGSUP_T_DETECT_US * `CHGSUP_CLK_MHZ)
// Charge safety timeout in milliseconds and derived cycles
`define CHGSUP_T_CHARGE_MS 1000
`define CHGSUP_CHARGE_CYCLES (`CHGSUP_T_CHARGE_MS * 1000 * `CHGSUP_CLK_MHZ)
`endif

// ---- rtl/chgsup_pkg.sv ----
// Types shared by the charge fault supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package chgsup_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    CHGSUP_IDLE = 4'h0,
    CHGSUP_PRE = 4'h1,
    CHGSUP_FAST = 4'h2,
    CHGSUP_REG = 4'h3,
    CHGSUP_DONE = 4'h4,
    CHGSUP_DET1 = 4'h5,
    CHGSUP_DET2 = 4'h6,
    CHGSUP_ABSENT = 4'h7,
    CHGSUP_TFLT_HI = 4'h8,
    CHGSUP_TFLT_LO = 4'h9,
    CHGSUP_OVP = 4'ha
  } chgsup_state_e;
endpackage : chgsup_pkg
`default_nettype wire

// ---- rtl/chgsup_tmr_if.sv ----
// Interface between the sequencer and its period timer.
// Assumes both ends share one clock.
`default_nettype none
interface chgsup_tmr_if;
  logic start; // Restart the count
  logic run; // Count while high
  logic [31:0] limit; // Terminal count
  logic expired; // Count reached limit
  modport ctl (output start, output run, output limit, input expired);
  modport tmr (input start, input run, input limit, output expired);
endinterface : chgsup_tmr_if
`default_nettype wire

// ---- rtl/chgsup_timer.sv ----
// Period timer used for the detection period and the charge safety timeout.
// Assumes a synchronous clock enable that freezes all state.
`default_nettype none
module chgsup_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  chgsup_tmr_if.tmr t
);
  logic [31:0] count; // Elapsed cycles

  // Count up, saturate at the limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 32'h0;
    end else if (ce_i) begin
      if (t.start) begin
        count <= 32'h0;
      end else if (t.run && count != t.limit) begin
        count <= count + 32'h1;
      end
    end
  end

  // Expiry is a level while saturated
  assign t.expired = (count == t.limit);
endmodule : chgsup_timer
`default_nettype wire

// ---- sim/chgsup_batt.sv ----
// Battery pack and comparator model facing the charge fault supervisor.
// Assumes flags are sampled on clk_i; lvl_i 0 low, 1 mid, 2 above recharge, 3 regulation.
`default_nettype none
module chgsup_batt (
  input wire logic clk_i,
  input wire logic pwm_i,
  input wire logic present_i,
  input wire logic [1:0] lvl_i,
  input wire logic full_i,
  output logic below_recharge_o,
  output logic below_precharge_o,
  output logic at_regulation_o,
  output logic term_current_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {below_recharge_o, below_precharge_o, at_regulation_o, term_current_o} = 4'h0;
  // Empty terminal swings with the converter; it draws no current when on
  always @(posedge clk_i) begin
    if (present_i) begin
      below_recharge_o <= lvl_i < 2'h2;
      below_precharge_o <= lvl_i == 2'h0;
      at_regulation_o <= lvl_i == 2'h3;
      term_current_o <= full_i;
    end else begin
      below_recharge_o <= !pwm_i;
      below_precharge_o <= !pwm_i;
      at_regulation_o <= pwm_i;
      term_current_o <= pwm_i;
    end
  end
endmodule : chgsup_batt
`default_nettype wire

// ---- sim/chgsup_top_assertions.sv ----
// Concurrent checks on the supervisor's ports, bound into chgsup_top.
// Assumes one clock domain with synchronous reset rst_i.
`default_nettype none
module chgsup_top_assertions (
  // Watched ports
  input wire logic clk_i, rst_i, clk_en_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic below_recharge_i, overvoltage_i, charge_enable_n_i,
  input wire logic detect_current_en_o, pwm_en_o, status_out_a_o, status_out_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go; // Enabled and charging allowed
  assign go = clk_en_i && !charge_enable_n_i;
  a_enable_off: assert property (clk_en_i && charge_enable_n_i |=>
    !pwm_en_o && !status_out_a_o && !status_out_b_o) else $error("output on while disabled");
  a_ovp_shutdown: assert property (clk_en_i && overvoltage_i |=>
    !pwm_en_o && !status_out_a_o && !status_out_b_o && !detect_current_en_o)
    else $error("overvoltage left power on");
  a_ovp_hold: assert property (go && $past(overvoltage_i) && !below_recharge_i |=>
    !pwm_en_o) else $error("overvoltage cleared early");
  a_status_exclusive: assert property (!(status_out_a_o && status_out_b_o))
    else $error("both status outputs on");
  a_done_quiet: assert property (status_out_b_o |-> !pwm_en_o)
    else $error("switching while complete");
  a_recharge_detect: assert property (go && !overvoltage_i && status_out_b_o
    && below_recharge_i |=> detect_current_en_o) else $error("no detection after recharge fall");
  a_detect_period: assert property (disable iff (rst_i || overvoltage_i || !go)
    $rose(detect_current_en_o) && $past(status_out_b_o) |-> detect_current_en_o[*7])
    else $error("detection period cut short");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  // Main scenarios reached
  c_detect: cover property (status_out_b_o ##1 detect_current_en_o);
  c_ovp: cover property (overvoltage_i && pwm_en_o);
  c_restart: cover property ($fell(detect_current_en_o) ##[1:12] status_out_a_o);
endmodule : chgsup_top_assertions
bind chgsup_top chgsup_top_assertions chk (.*);
`default_nettype wire

// ---- sim/test_chgsup_top.sv ----
// Self-checking bench for chgsup_top with a battery model on its flags.
// Assumes short counts: detection 8 cycles, charge timeout 64 cycles.
`default_nettype none
module test_chgsup_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic en_n = 1, timer_termination_enable = 1, rate = 0, ovp = 0, present = 1, full = 0;
  logic [1:0] lvl = 2'h2;
  logic brc, bpc, areg, term, det, fsel, pwm, sa, sb;
  int err_total = 0, n_tests = 0;
  chgsup_top #(.DETECT_CYCLES(32'h8), .CHARGE_CYCLES(32'h40)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .clk_en_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .below_recharge_i(brc), .below_precharge_i(bpc), .at_regulation_i(areg),
    .overvoltage_i(ovp), .term_current_i(term), .charge_enable_n_i(en_n),
    .timer_termination_enable_i(timer_termination_enable), .charge_rate_select_i(rate),
    .detect_current_en_o(det), .fast_current_sel_o(fsel), .pwm_en_o(pwm),
    .status_out_a_o(sa), .status_out_b_o(sb));
  chgsup_batt battery_sense_pin (.clk_i(clk_i), .pwm_i(pwm), .present_i(present), .lvl_i(lvl),
    .full_i(full), .below_recharge_o(brc), .below_precharge_o(bpc),
    .at_regulation_o(areg), .term_current_o(term));
  initial forever #10 clk_i = ~clk_i;
  // One classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wd} <= {1'b1, 1'b1, w, a, s, d};
    @(posedge clk_i);
    for (int n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    // A missing answer counts as a mismatch
    chk(ack, 1'b1);
    q = rd;
    {cyc, stb} <= 2'h0;
  endtask : bus
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Bounded wait, sampled away from the active edge
  task automatic wt(ref logic s, input logic v);
    for (int n = 0; n < 300 && s !== v; n++) @(negedge clk_i);
  endtask : wt
  task automatic restart;
    @(posedge clk_i) en_n <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk({pwm, sa, sb}, 0);
    @(posedge clk_i) en_n <= 1'b0;
  endtask : restart
  task automatic t_regs;
    bus(0, 4'h0, 4'hf, 0);
    chk(q, 32'h2);
    bus(0, 4'h8, 4'hf, 0);
    chk(q, 32'h8);
    bus(0, 4'hc, 4'hf, 0);
    chk(q, 0);
    bus(1, 4'h0, 4'h0, 32'h1);
    bus(0, 4'h0, 4'hf, 0);
    chk(q, 32'h2);
  endtask : t_regs
  task automatic t_absent;
    int c;
    @(posedge clk_i) present <= 1'b0;
    restart;
    wt(det, 1);
    for (c = 0; det === 1'b1 && c < 99; c++) @(negedge clk_i);
    chk(c >= 8, 1);
    wt(pwm, 0);
    chk({pwm, det, sa, sb}, 0);
    wt(det, 1);
    chk(det, 1);
    @(posedge clk_i) present <= 1'b1;
  endtask : t_absent
  task automatic t_fail;
    @(posedge clk_i) {lvl, full} <= 3'h7;
    restart;
    wt(sb, 1);
    chk(sb, 1);
    @(posedge clk_i) {lvl, full} <= 3'h2;
    wt(det, 1);
    chk(det, 1);
    wt(sa, 1);
    chk(sa, 1);
  endtask : t_fail
  task automatic t_timeout;
    restart;
    wt(det, 1);
    chk(pwm, 0);
    repeat (20) @(negedge clk_i);
    chk(det, 1);
    @(posedge clk_i) lvl <= 2'h2;
    repeat (3) @(negedge clk_i);
    chk(det, 0);
    @(posedge clk_i) timer_termination_enable <= 1'b0;
    @(posedge clk_i) timer_termination_enable <= 1'b1;
    wt(sa, 1);
    chk(sa, 1);
    wt(sa, 0);
    chk({sa, det}, 0);
    @(posedge clk_i) lvl <= 2'h1;
    wt(det, 1);
    chk(det, 1);
  endtask : t_timeout
  task automatic t_ovp;
    @(posedge clk_i) lvl <= 2'h2;
    restart;
    wt(sa, 1);
    @(posedge clk_i) ovp <= 1'b1;
    @(posedge clk_i) ovp <= 1'b0;
    @(negedge clk_i);
    chk({pwm, sa, sb, det}, 0);
    repeat (5) @(negedge clk_i);
    chk(pwm, 0);
    @(posedge clk_i) lvl <= 2'h1;
    wt(pwm, 1);
    chk(pwm, 1);
  endtask : t_ovp
  task automatic t_host;
    bus(1, 4'h0, 4'hf, 32'h3);
    restart;
    wt(sa, 1);
    chk(fsel, 0);
    @(posedge clk_i) rate <= 1'b1;
    repeat (100) @(negedge clk_i);
    chk({fsel, sa}, 2'h3);
    @(posedge clk_i) {rate, lvl} <= 3'h3;
    repeat (3) @(negedge clk_i);
    bus(0, 4'h4, 4'hf, 0);
    chk(q[3:0], 4'h3);
  endtask : t_host
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_absent;
    t_fail;
    @(posedge clk_i) lvl <= 2'h1;
    t_timeout;
    t_ovp;
    t_host;
    print_verdict;
  end
  // Hang guard well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
endmodule : test_chgsup_top
`default_nettype wire
